// ### rtl/backlight_regs.vh
// register offsets, field positions, reset values and decode constants for the backlight bank
`ifndef BACKLIGHT_REGS_VH
`define BACKLIGHT_REGS_VH

// --------------------------------------------------------------------------
// bus addressing
// --------------------------------------------------------------------------
`define DEV_ADDR 7'h20
`define ADDR_MSB 7
`define ADDR_LSB 1

// --------------------------------------------------------------------------
// register offsets
// --------------------------------------------------------------------------
`define OFS_SETTING 8'h12
`define OFS_SINK_DISABLE_AND_SOFTSTART 8'h13
`define OFS_BOOST_MONITOR_VOLTAGE 8'h14
`define OFS_SINK1_CURRENT_READBACK 8'h15
`define OFS_SINK2_CURRENT_READBACK 8'h16
`define OFS_SINK3_CURRENT_READBACK 8'h17
`define OFS_SINK4_CURRENT_READBACK 8'h18
`define OFS_SINK5_CURRENT_READBACK 8'h19

// --------------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------------
`define SET_SS_OFF_BIT 3
`define SET_SSL_BIT 2
`define SET_SHORTED_LED_THRESHOLD_MSB 1
`define SET_SHORTED_LED_THRESHOLD_LSB 0
`define DIS_SLOW_SS_BIT 6
`define DIS_SINK_MSB 5
`define DIS_SINK_LSB 0

// --------------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------------
`define SETTING_RST 4'h0
`define SINK_OFF_RST 6'h00
`define SLOW_SS_RST 1'b0
`define READBACK_RST 8'h00

// --------------------------------------------------------------------------
// decode tables: spread in percent, threshold in tenths of a volt
// --------------------------------------------------------------------------
`define SPREAD_WIDE_PCT 4'h6
`define SPREAD_NARROW_PCT 4'h3
`define SPREAD_NONE_PCT 4'h0
`define SHORTED_LED_THRESHOLD_OFF 2'h0
`define SHORTED_LED_THRESHOLD_3V 2'h1
`define SHORTED_LED_THRESHOLD_6V 2'h2
`define SHORTED_LED_THRESHOLD_8V 2'h3
`define THRESH_3V_DV 8'h1e
`define THRESH_6V_DV 8'h3c
`define THRESH_8V_DV 8'h50
`define THRESH_NONE_DV 8'h00

// --------------------------------------------------------------------------
// byte framing
// --------------------------------------------------------------------------
`define BITS_PER_BYTE 4'h8

`endif

// ### rtl/line_sampler.v
// bus line sampler: delays scl and sda one cycle and flags edges and start/stop
`timescale 1ns/1ps

module line_sampler
(
    input wire clk_i,
    input wire rst_n_i,
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output wire scl_rise_o,
    output wire scl_fall_o,
    output wire start_o,
    output wire stop_o
);

    reg scl_q;

    // one stage is enough: the pins are already synchronous to clk_i
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            scl_q <= 1'b1;
            sda_o <= 1'b1;
        end
        else
        begin
            scl_q <= scl_i;
            sda_o <= sda_i;
        end
    end

    // edges; sda moving while scl is high frames a transfer
    assign scl_rise_o = scl_i & ~scl_q;
    assign scl_fall_o = ~scl_i & scl_q;
    assign start_o = scl_i & scl_q & sda_o & ~sda_i;
    assign stop_o = scl_i & scl_q & ~sda_o & sda_i;

endmodule

// ### rtl/backlight_cfg_readback_regs.v
// backlight setting, sink disable and readback registers behind a two-wire slave
`timescale 1ns/1ps
`include "backlight_regs.vh"

module backlight_cfg_readback_regs
(
    input wire clk_i,
    input wire arst_n_i,
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_o,
    input wire master_turn_on_i,
    input wire meas_update_i,
    input wire [7:0] boost_monitor_code_i,
    input wire [7:0] sink1_current_code_i,
    input wire [7:0] sink2_current_code_i,
    input wire [7:0] sink3_current_code_i,
    input wire [7:0] sink4_current_code_i,
    input wire [7:0] sink5_current_code_i,
    output reg spread_enable_o,
    output reg [3:0] spread_pct_o,
    output reg shorted_led_det_en_o,
    output reg [7:0] shorted_led_threshold_o,
    output reg slow_softstart_select_o,
    output reg [5:0] sink_off_o
);

    // ----------------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'h0, ST_ADDR = 4'h1, ST_AACK = 4'h2;
    localparam [3:0] ST_PTR = 4'h3, ST_PACK = 4'h4, ST_WR = 4'h5;
    localparam [3:0] ST_WACK = 4'h6, ST_RD = 4'h7, ST_RACK = 4'h8;
    reg [1:0] rst_sync_q;
    wire rst_n, sda_s, scl_rise, scl_fall, start, stop;
    wire [7:0] rd_byte;
    reg [3:0] state_q, cnt_q;
    reg [7:0] shift_q, ptr_q;
    reg rw_q, nack_q, slow_ss_q;
    reg [3:0] setting_q;
    reg [5:0] sink_dis_q;
    reg [7:0] boost_monitor_pin_q, cur1_q, cur2_q, cur3_q, cur4_q, cur5_q;

    // ----------------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------------
    // asynchronous assert, release after two clean edges
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // ----------------------------------------------------------------------
    // line sampling
    // ----------------------------------------------------------------------
    line_sampler u_line_sampler
    (
        .clk_i(clk_i), .rst_n_i(rst_n), .scl_i(scl_i),
        .sda_i(sda_i), .sda_o(sda_s), .scl_rise_o(scl_rise),
        .scl_fall_o(scl_fall), .start_o(start), .stop_o(stop)
    );

    // ----------------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------------
    // unmapped offsets and unused bits read as zero
    function [7:0] reg_read;
        input [7:0] ofs;
        begin
            case (ofs)
                `OFS_SETTING: reg_read = {4'h0, setting_q};
                `OFS_SINK_DISABLE_AND_SOFTSTART: reg_read = {1'b0, slow_ss_q, sink_dis_q};
                `OFS_BOOST_MONITOR_VOLTAGE: reg_read = boost_monitor_pin_q;
                `OFS_SINK1_CURRENT_READBACK: reg_read = cur1_q;
                `OFS_SINK2_CURRENT_READBACK: reg_read = cur2_q;
                `OFS_SINK3_CURRENT_READBACK: reg_read = cur3_q;
                `OFS_SINK4_CURRENT_READBACK: reg_read = cur4_q;
                `OFS_SINK5_CURRENT_READBACK: reg_read = cur5_q;
                default: reg_read = 8'h00;
            endcase
        end
    endfunction
    assign rd_byte = reg_read(ptr_q); // byte the pointer selects, loaded at each read start

    // ----------------------------------------------------------------------
    // byte engine
    // ----------------------------------------------------------------------
    // data is sampled on scl rise and changed on scl fall; start wins over all
    always @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            nack_q <= 1'b0;
            sda_oe_o <= 1'b0;
            setting_q <= `SETTING_RST;
            sink_dis_q <= `SINK_OFF_RST;
            slow_ss_q <= `SLOW_SS_RST;
        end
        else if (start)
        begin
            state_q <= ST_ADDR;
            cnt_q <= 4'h0;
            sda_oe_o <= 1'b0;
        end
        else if (stop)
        begin
            state_q <= ST_IDLE;
            sda_oe_o <= 1'b0;
        end
        else if (scl_rise)
        begin
            case (state_q)
                ST_ADDR, ST_PTR, ST_WR:
                begin
                    shift_q <= {shift_q[6:0], sda_s};
                    cnt_q <= cnt_q + 4'h1;
                end
                ST_RD: cnt_q <= cnt_q + 4'h1;
                ST_RACK: nack_q <= sda_s;
                default: cnt_q <= cnt_q;
            endcase
        end
        else if (scl_fall)
        begin
            case (state_q)
                ST_ADDR:
                    if (cnt_q == `BITS_PER_BYTE)
                    begin
                        if (shift_q[`ADDR_MSB:`ADDR_LSB] == `DEV_ADDR)
                        begin
                            rw_q <= shift_q[0];
                            sda_oe_o <= 1'b1;
                            state_q <= ST_AACK;
                        end
                        else
                            state_q <= ST_IDLE; // another device's address
                    end
                ST_AACK:
                begin
                    cnt_q <= 4'h0;
                    if (rw_q)
                    begin
                        shift_q <= rd_byte;
                        sda_oe_o <= ~rd_byte[7];
                        state_q <= ST_RD;
                    end
                    else
                    begin
                        sda_oe_o <= 1'b0;
                        state_q <= ST_PTR;
                    end
                end
                ST_PTR:
                    if (cnt_q == `BITS_PER_BYTE)
                    begin
                        ptr_q <= shift_q;
                        sda_oe_o <= 1'b1;
                        state_q <= ST_PACK;
                    end
                ST_PACK, ST_WACK:
                begin
                    if (state_q == ST_WACK)
                        ptr_q <= ptr_q + 8'h01;
                    sda_oe_o <= 1'b0;
                    cnt_q <= 4'h0;
                    state_q <= ST_WR;
                end
                ST_WR:
                    if (cnt_q == `BITS_PER_BYTE)
                    begin
                        // readback offsets have no write path here
                        case (ptr_q)
                            `OFS_SETTING: setting_q <= shift_q[`SET_SS_OFF_BIT:`SET_SHORTED_LED_THRESHOLD_LSB];
                            `OFS_SINK_DISABLE_AND_SOFTSTART:
                            begin
                                slow_ss_q <= shift_q[`DIS_SLOW_SS_BIT];
                                sink_dis_q <= shift_q[`DIS_SINK_MSB:`DIS_SINK_LSB];
                            end
                            default: setting_q <= setting_q;
                        endcase
                        sda_oe_o <= 1'b1;
                        state_q <= ST_WACK;
                    end
                ST_RD:
                    if (cnt_q == `BITS_PER_BYTE)
                    begin
                        sda_oe_o <= 1'b0;
                        ptr_q <= ptr_q + 8'h01;
                        state_q <= ST_RACK;
                    end
                    else
                    begin
                        shift_q <= {shift_q[6:0], 1'b0};
                        sda_oe_o <= ~shift_q[6];
                    end
                ST_RACK:
                    if (nack_q)
                        state_q <= ST_IDLE; // master ends the burst
                    else
                    begin
                        cnt_q <= 4'h0;
                        shift_q <= rd_byte;
                        sda_oe_o <= ~rd_byte[7];
                        state_q <= ST_RD;
                    end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // measurement capture
    // ----------------------------------------------------------------------
    // only the measurement strobe loads these; the bus never does
    always @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            boost_monitor_pin_q <= `READBACK_RST;
            cur1_q <= `READBACK_RST;
            cur2_q <= `READBACK_RST;
            cur3_q <= `READBACK_RST;
            cur4_q <= `READBACK_RST;
            cur5_q <= `READBACK_RST;
        end
        else if (meas_update_i)
        begin
            boost_monitor_pin_q <= boost_monitor_code_i;
            cur1_q <= sink1_current_code_i;
            cur2_q <= sink2_current_code_i;
            cur3_q <= sink3_current_code_i;
            cur4_q <= sink4_current_code_i;
            cur5_q <= sink5_current_code_i;
        end
    end

    // ----------------------------------------------------------------------
    // control decode
    // ----------------------------------------------------------------------
    // registered so every control output comes from a flop
    always @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sda_o <= 1'b0;
            spread_enable_o <= 1'b0;
            spread_pct_o <= `SPREAD_NONE_PCT;
            shorted_led_det_en_o <= 1'b0;
            shorted_led_threshold_o <= `THRESH_NONE_DV;
            slow_softstart_select_o <= `SLOW_SS_RST;
            sink_off_o <= `SINK_OFF_RST;
        end
        else
        begin
            sda_o <= 1'b0; // open drain: only ever pulls low
            spread_enable_o <= ~setting_q[`SET_SS_OFF_BIT];
            if (setting_q[`SET_SS_OFF_BIT])
                spread_pct_o <= `SPREAD_NONE_PCT;
            else if (setting_q[`SET_SSL_BIT])
                spread_pct_o <= `SPREAD_NARROW_PCT;
            else
                spread_pct_o <= `SPREAD_WIDE_PCT;
            shorted_led_det_en_o <= (setting_q[`SET_SHORTED_LED_THRESHOLD_MSB:`SET_SHORTED_LED_THRESHOLD_LSB] != `SHORTED_LED_THRESHOLD_OFF);
            case (setting_q[`SET_SHORTED_LED_THRESHOLD_MSB:`SET_SHORTED_LED_THRESHOLD_LSB])
                `SHORTED_LED_THRESHOLD_3V: shorted_led_threshold_o <= `THRESH_3V_DV;
                `SHORTED_LED_THRESHOLD_6V: shorted_led_threshold_o <= `THRESH_6V_DV;
                `SHORTED_LED_THRESHOLD_8V: shorted_led_threshold_o <= `THRESH_8V_DV;
                default: shorted_led_threshold_o <= `THRESH_NONE_DV;
            endcase
            slow_softstart_select_o <= slow_ss_q;
            // sink set frozen while turned on; late changes are unsupported anyway
            if (!master_turn_on_i)
                sink_off_o <= sink_dis_q;
        end
    end

endmodule

// ### verification/backlight_regs_checker.sv
// port-level assertions for the backlight register bank
`timescale 1ns/1ps
module backlight_regs_checker
(
    input wire clk_i,
    input wire arst_n_i,
    input wire scl_i,
    input wire sda_o,
    input wire sda_oe_o,
    input wire master_turn_on_i,
    input wire spread_enable_o,
    input wire [3:0] spread_pct_o,
    input wire shorted_led_det_en_o,
    input wire [7:0] shorted_led_threshold_o,
    input wire slow_softstart_select_o,
    input wire [5:0] sink_off_o
);
// ------------------------------------------------------------
// assertions
// ------------------------------------------------------------
default clocking cb @(posedge clk_i); endclocking
default disable iff (!arst_n_i);
// spread figures only 6 or 3 while on, 0 while off
spread_map_a: assert property (spread_enable_o |-> spread_pct_o inside {4'h6, 4'h3})
    else $error("spread percent not 6 or 3 while spread on");
spread_off_a: assert property (!spread_enable_o |-> spread_pct_o == 4'h0)
    else $error("spread percent nonzero while spread off");
thresh_code_a: assert property (shorted_led_threshold_o inside {8'h00, 8'h1e, 8'h3c, 8'h50})
    else $error("threshold outside the four codes");
det_enable_a: assert property (shorted_led_det_en_o == (shorted_led_threshold_o != 8'h00))
    else $error("detection enable disagrees with threshold");
// disables must not move once the driver is on
sink_freeze_a: assert property (master_turn_on_i && $past(master_turn_on_i) |-> $stable(sink_off_o))
    else $error("sink disables moved while turned on");
// async reset clears config outputs at every edge it is held
reset_clear_a: assert property (disable iff (1'b0) !arst_n_i |-> sink_off_o == 6'h00
    && !slow_softstart_select_o && !sda_oe_o && spread_pct_o == 4'h0)
    else $error("outputs not cleared in reset");
// register loads land only in the scl low phase of a write
cfg_quiet_a: assert property (scl_i && $past(scl_i) && $past(scl_i, 2) |->
    $stable(slow_softstart_select_o) && $stable(shorted_led_threshold_o))
    else $error("config moved during scl high");
data_hold_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
    else $error("data drive changed during scl high");
ack_edge_a: assert property ($rose(sda_oe_o) |-> !scl_i && !$past(scl_i) && sda_o == 1'b0)
    else $error("data drive started outside scl low");
cover property ($rose(slow_softstart_select_o));
cover property (master_turn_on_i && $rose(sda_oe_o));
cover property ($fell(spread_enable_o));
endmodule

bind backlight_cfg_readback_regs backlight_regs_checker i_chk
(
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .scl_i(scl_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .master_turn_on_i(master_turn_on_i),
    .spread_enable_o(spread_enable_o),
    .spread_pct_o(spread_pct_o),
    .shorted_led_det_en_o(shorted_led_det_en_o),
    .shorted_led_threshold_o(shorted_led_threshold_o),
    .slow_softstart_select_o(slow_softstart_select_o),
    .sink_off_o(sink_off_o)
);

// ### verification/i2c_host_model.sv
// two-wire bus host: drives scl, releases or pulls sda
`timescale 1ns/1ps
module i2c_host_model
(
    input wire clk_i,
    input wire sda_i,
    output reg scl_o,
    output reg sda_o
);
// ------------------------------------------------------------
// bus phases, all moves 1 ns after a clock edge
// ------------------------------------------------------------
initial
begin
    scl_o = 1'b1;
    sda_o = 1'b1;
end
task automatic w(input integer n);
    repeat (n) @(posedge clk_i);
    #1;
endtask
// set both lines then hold 3 cycles, matching the 3-cycle minimum phase
task automatic sw(input logic c, input logic d);
    scl_o = c;
    sda_o = d;
    w(3);
endtask
// sda only moves while scl is low, except in start and stop
task automatic bit_x(input logic b, output logic r);
    sw(1'b0, b);
    sw(1'b1, b);
    w(2);
    r = sda_i;
    sw(1'b0, b);
endtask
task automatic start;
    sw(scl_o, 1'b1);
    sw(1'b1, 1'b1);
    sw(1'b1, 1'b0);
    sw(1'b0, 1'b0);
endtask
task automatic stop;
    sw(1'b0, 1'b0);
    sw(1'b1, 1'b0);
    sw(1'b1, 1'b1);
endtask
task automatic wbyte(input logic [7:0] b, output logic a);
    integer i;
    logic r;
    for (i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    a = ~r;
endtask
// last high sends nack so the device lets go of sda
task automatic rbyte(input logic last, output logic [7:0] b);
    integer i;
    logic r;
    for (i = 7; i >= 0; i--)
    begin
        bit_x(1'b1, r);
        b[i] = r;
    end
    bit_x(last, r);
endtask
endmodule

// ### verification/backlight_cfg_readback_regs_tb.sv
// self-checking bench for the backlight register bank
`timescale 1ns/1ps
module backlight_cfg_readback_regs_tb;
// ------------------------------------------------------------
// wiring, clock, checks
// ------------------------------------------------------------
reg clk = 1'b0;
reg arst_n = 1'b1;
reg ton = 1'b0;
reg upd = 1'b0;
reg [7:0] code [0:5];
integer n_mismatch = 0;
integer n_tests = 0;
wire scl, h_sda, oe, dq, en, det, slow;
wire [3:0] pct;
wire [7:0] thr;
wire [5:0] off;
// pull-up, so released reads 1; a drive shows the data pin value the device gives
wire sda = h_sda & (~oe | dq);
initial
begin
    forever #5 clk = ~clk;
end
i2c_host_model h (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(h_sda));
backlight_cfg_readback_regs i_dut
(
    .clk_i(clk), .arst_n_i(arst_n), .scl_i(scl), .sda_i(sda), .sda_o(dq), .sda_oe_o(oe),
    .master_turn_on_i(ton), .meas_update_i(upd), .boost_monitor_code_i(code[0]),
    .sink1_current_code_i(code[1]), .sink2_current_code_i(code[2]),
    .sink3_current_code_i(code[3]), .sink4_current_code_i(code[4]),
    .sink5_current_code_i(code[5]), .spread_enable_o(en), .spread_pct_o(pct),
    .shorted_led_det_en_o(det), .shorted_led_threshold_o(thr),
    .slow_softstart_select_o(slow), .sink_off_o(off)
);
task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
        n_mismatch++;
        $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
endtask
task automatic summarize;
    if (n_mismatch == 0 && n_tests > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask
task automatic wr(input logic [7:0] o, input logic [7:0] d);
    logic a;
    h.start();
    h.wbyte(8'h40, a);
    h.wbyte(o, a);
    h.wbyte(d, a);
    chk("wr_ack", a, 8'h01);
    h.stop();
endtask
task automatic rd(input logic [7:0] o, output logic [7:0] d);
    logic a;
    h.start();
    h.wbyte(8'h40, a);
    h.wbyte(o, a);
    h.start();
    h.wbyte(8'h41, a);
    chk("rd_ack", a, 8'h01);
    h.rbyte(1'b1, d);
    h.stop();
endtask
// ------------------------------------------------------------
// scenarios
// ------------------------------------------------------------
task automatic t_reset;
    integer i;
    logic [7:0] d;
    chk("spread_en", en, 8'h01);
    chk("spread_pct", pct, 8'h06);
    chk("slow_ss", slow, 8'h00);
    chk("sink_off", off, 8'h00);
    for (i = 0; i < 8; i++)
    begin
        rd(8'h12 + i[7:0], d);
        chk("reset_rd", d, 8'h00);
    end
endtask
// every code of the four setting bits
task automatic t_setting;
    integer v;
    logic [7:0] d;
    logic [7:0] t [0:3];
    t = '{8'h00, 8'h1e, 8'h3c, 8'h50};
    for (v = 0; v < 16; v++)
    begin
        wr(8'h12, v[7:0]);
        chk("spread_en", en, !v[3]);
        chk("spread_pct", pct, v[3] ? 4'h0 : (v[2] ? 4'h3 : 4'h6));
        chk("det_en", det, v[1:0] != 2'b00);
        chk("thresh", thr, t[v[1:0]]);
        rd(8'h12, d);
        chk("set_rd", d, v[7:0]);
    end
endtask
task automatic t_disable;
    logic [7:0] d;
    wr(8'h13, 8'hff);
    rd(8'h13, d);
    chk("dis_rd", d, 8'h7f);
    chk("slow_ss", slow, 8'h01);
    chk("sink_off", off, 8'h3f);
    wr(8'h13, 8'h41);
    chk("sink_off", off, 8'h01);
    ton = 1'b1;
    wr(8'h13, 8'h22);
    chk("frozen", off, 8'h01);
    chk("slow_ss", slow, 8'h00);
    ton = 1'b0;
    h.w(3);
    chk("sink_off", off, 8'h22);
endtask
// readbacks load on the pulse only and shrug off host writes
task automatic t_readback;
    integer i;
    logic a;
    logic [7:0] d;
    logic [7:0] e [0:5];
    e = '{8'hff, 8'h01, 8'hfe, 8'h80, 8'h5a, 8'h33};
    for (i = 0; i < 6; i++) code[i] = e[i];
    upd = 1'b1;
    h.w(1);
    upd = 1'b0;
    for (i = 0; i < 6; i++) code[i] = ~e[i];
    for (i = 0; i < 6; i++)
    begin
        wr(8'h14 + i[7:0], 8'h3c);
        rd(8'h14 + i[7:0], d);
        chk("readback", d, e[i]);
    end
    rd(8'h20, d);
    chk("unmapped", d, 8'h00);
    h.start();
    h.wbyte(8'h42, a);
    chk("other_addr", a, 8'h00);
    h.stop();
endtask
initial
begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    summarize();
end
initial
begin
    for (int k = 0; k < 6; k++) code[k] = 8'h00;
    #2 arst_n = 1'b0;
    repeat (20) @(posedge clk);
    #1 arst_n = 1'b1;
    h.w(10);
    t_reset();
    t_setting();
    t_disable();
    t_readback();
    summarize();
end
endmodule
